// *** gls_defines.vh ***
// Operation
// - Feedback delay steps 10/50 ms, 0.5 s.
// - Feedback must follow drive within delay.
// - Spring option: de-energised magnet means locked.
// - Mandatory mode: door must open before relock.
// - No-door-sense: ignore door, use feedback only.
// - Fault flag high on fault when enabled.
// - Door open while locked is a fault.
// - With door: safe only closed and locked.
// - Without door: safe when locked, no fault.
// - Request rise drops safe before drive changes.
// - Drive releases only after release delay.
// - No-door-sense: relock as request falls.
// - Door sense: relock on withdrawal and closed.
// - Safe returns once relock is confirmed.
// - Release delay steps 100 ms, 0.5 s, 5 s.
// - Mandatory mode: fault if door never opened.
`ifndef GLS_DEFINES_VH
`define GLS_DEFINES_VH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define GLS_ADDR_CTRL     8'h00
`define GLS_ADDR_RELDLY   8'h04
`define GLS_ADDR_FBDLY    8'h08
`define GLS_ADDR_STATUS   8'h0c
`define GLS_ADDR_IRQ_STAT 8'h10
`define GLS_ADDR_IRQ_EN   8'h14
`define GLS_ADDR_IRQ_CLR  8'h18

// ----------------------------------------------------------------
// Control fields and reset values
// ----------------------------------------------------------------
`define GLS_CTRL_NDS      0
`define GLS_CTRL_MAND     1
`define GLS_CTRL_SPRING   2
`define GLS_CTRL_FEN      3
`define GLS_CTRL_FCLR     4
`define GLS_CTRL_RST      4'h4
`define GLS_RELDLY_RST    5'h05
`define GLS_FBDLY_RST     5'h09

// ----------------------------------------------------------------
// Interrupt event bits
// ----------------------------------------------------------------
`define GLS_EV_FAULT      0
`define GLS_EV_SAFE_UP    1
`define GLS_EV_SAFE_DN    2
`define GLS_EV_DRIVE      3

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define GLS_CLK_PERIOD_NS 40
`define GLS_TICK_NS       1000000
`define GLS_TICK_CYCLES   (`GLS_TICK_NS / `GLS_CLK_PERIOD_NS)

// Release delay table: three ranges, index breaks at 10 and 28.
`define GLS_RD_BRK1       5'd10
`define GLS_RD_BRK2       5'd28
`define GLS_RD_STEP1_MS   15'd100
`define GLS_RD_BASE2_MS   15'd1500
`define GLS_RD_STEP2_MS   15'd500
`define GLS_RD_BASE3_MS   15'd15000
`define GLS_RD_STEP3_MS   15'd5000

// Feedback delay table: three ranges, index breaks at 9 and 27.
`define GLS_FD_BRK1       5'd9
`define GLS_FD_BRK2       5'd27
`define GLS_FD_STEP1_MS   15'd10
`define GLS_FD_BASE2_MS   15'd150
`define GLS_FD_STEP2_MS   15'd50
`define GLS_FD_BASE3_MS   15'd1500
`define GLS_FD_STEP3_MS   15'd500

`endif

// *** gls_tick.v ***
`timescale 1ns/100ps
`default_nettype none

// ----------------------------------------------------------------
// Millisecond enable divider
// ----------------------------------------------------------------
module gls_tick #(
  parameter DIV = 25000
) (
  input  wire pclk,
  input  wire presetn,
  output reg  tick_q
);

  reg [15:0] cnt_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q  <= 16'h0000;
      tick_q <= 1'b0;
    end else if (cnt_q == DIV[15:0] - 16'h0001) begin
      cnt_q  <= 16'h0000;
      tick_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + 16'h0001;
      tick_q <= 1'b0;
    end
  end

endmodule // gls_tick

`default_nettype wire

// *** gls_guard_lock.v ***
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "gls_defines.vh"

module gls_guard_lock #(
  parameter TICK_CYCLES = `GLS_TICK_CYCLES
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        release_req,
  input  wire        magnet_fbk,
  input  wire        door_closed,
  output reg         magnet_drive,
  output reg         safe_out,
  output reg         fault_flag,
  output reg         irq
);

  // --------------------------------------------------------------
  // States
  // --------------------------------------------------------------
  localparam [2:0] S_INIT   = 3'd0;
  localparam [2:0] S_LOCKED = 3'd1;
  localparam [2:0] S_DELAY  = 3'd2;
  localparam [2:0] S_OPEN   = 3'd3;
  localparam [2:0] S_RELOCK = 3'd4;
  localparam [2:0] S_FAULT  = 3'd5;

  reg  [2:0]  sync1_q;
  reg  [2:0]  sync2_q;
  reg  [3:0]  ctrl_q;
  reg  [4:0]  reldly_q;
  reg  [4:0]  fbdly_q;
  reg  [3:0]  ist_q;
  reg  [3:0]  ien_q;
  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg         drive_d;
  reg         safe_d;
  reg         fault_q;
  reg         fset;
  reg         dseen_q;
  reg         dseen_d;
  reg  [14:0] dly_cnt_q;
  reg  [14:0] fb_cnt_q;
  reg         fb_pend_q;
  reg  [1:0]  warm_q;
  reg  [3:0]  ist_d;
  reg  [31:0] rdata_d;
  reg         rerr_d;
  wire        tick;
  wire [2:0]  pin_in;

  // --------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------
  assign pin_in = {door_closed, magnet_fbk, release_req};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= pin_in[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  wire req  = sync2_q[0];
  wire fbk  = sync2_q[1];
  wire door = sync2_q[2];

  gls_tick #(
    .DIV     (TICK_CYCLES)
  ) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .tick_q  (tick)
  );

  // --------------------------------------------------------------
  // Delay tables
  // --------------------------------------------------------------
  function [14:0] rel_ms;
    input [4:0] i;
    begin
      if (i <= `GLS_RD_BRK1) begin
        rel_ms = `GLS_RD_STEP1_MS * {10'd0, i};
      end else if (i <= `GLS_RD_BRK2) begin
        rel_ms = `GLS_RD_BASE2_MS +
                 `GLS_RD_STEP2_MS * {10'd0, i - 5'd11};
      end else begin
        rel_ms = `GLS_RD_BASE3_MS +
                 `GLS_RD_STEP3_MS * {10'd0, i - 5'd29};
      end
    end
  endfunction

  function [14:0] fb_ms;
    input [4:0] i;
    begin
      if (i <= `GLS_FD_BRK1) begin
        fb_ms = `GLS_FD_STEP1_MS * {10'd0, i + 5'd1};
      end else if (i <= `GLS_FD_BRK2) begin
        fb_ms = `GLS_FD_BASE2_MS +
                `GLS_FD_STEP2_MS * {10'd0, i - 5'd10};
      end else begin
        fb_ms = `GLS_FD_BASE3_MS +
                `GLS_FD_STEP3_MS * {10'd0, i - 5'd28};
      end
    end
  endfunction

  wire [14:0] rel_lim = rel_ms(reldly_q);
  wire [14:0] fb_lim  = fb_ms(fbdly_q);

  // --------------------------------------------------------------
  // Mode decode and supervision terms
  // --------------------------------------------------------------
  wire nds      = ctrl_q[`GLS_CTRL_NDS];
  wire mand     = ctrl_q[`GLS_CTRL_MAND] & ~nds;
  wire spring   = ctrl_q[`GLS_CTRL_SPRING];
  wire lock_lvl = ~spring;
  wire rel_lvl  = spring;
  wire door_ok  = nds | door;
  wire fbk_lock = (fbk == lock_lvl);

  // The timers count whole millisecond ticks, so the first tick may
  // be partial; comparing with greater-than keeps both limits honest.
  wire dly_done = (rel_lim == 15'd0) | (dly_cnt_q > rel_lim);
  wire fb_err   = fb_pend_q ? (fb_cnt_q > fb_lim)
                            : (fbk != magnet_drive);
  wire door_err = ~nds & ~door &
                  ((state_q == S_LOCKED) | (state_q == S_DELAY));

  // --------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------
  always @* begin
    state_d = state_q;
    drive_d = magnet_drive;
    safe_d  = 1'b0;
    fset    = 1'b0;
    dseen_d = dseen_q;
    case (state_q)
      S_INIT: begin
        drive_d = lock_lvl;
        if (fault_q) begin
          state_d = S_FAULT;
        end else if (!req && fbk_lock && door_ok && !fb_pend_q) begin
          state_d = S_LOCKED;
          safe_d  = 1'b1;
        end
      end
      S_LOCKED: begin
        drive_d = lock_lvl;
        if (req) begin
          state_d = S_DELAY;
        end else begin
          safe_d = fbk_lock & door_ok;
        end
      end
      S_DELAY: begin
        if (!req) begin
          state_d = S_LOCKED;
          safe_d  = fbk_lock & door_ok;
        end else if (dly_done) begin
          drive_d = rel_lvl;
          dseen_d = 1'b0;
          state_d = S_OPEN;
        end
      end
      S_OPEN: begin
        drive_d = rel_lvl;
        if (!nds && !door) begin
          dseen_d = 1'b1;
        end
        if (!req && door_ok) begin
          drive_d = lock_lvl;
          state_d = S_RELOCK;
        end
      end
      S_RELOCK: begin
        drive_d = lock_lvl;
        if (req) begin
          state_d = S_DELAY;
        end else if (fbk_lock && door_ok && !fb_pend_q) begin
          if (mand && !dseen_q) begin
            fset = 1'b1;
          end else begin
            state_d = S_LOCKED;
            safe_d  = 1'b1;
          end
        end
      end
      S_FAULT: begin
        drive_d = lock_lvl;
        if (!fault_q) begin
          state_d = S_INIT;
        end
      end
      default: begin
        state_d = S_INIT;
        drive_d = lock_lvl;
      end
    endcase
    if (fb_err || door_err || fset) begin
      state_d = S_FAULT;
      drive_d = lock_lvl;
      safe_d  = 1'b0;
    end
  end

  wire fclr_wr = psel & penable & pready & pwrite &
                 (paddr == `GLS_ADDR_CTRL) & pwdata[`GLS_CTRL_FCLR];
  wire f_any   = fb_err | door_err | fset;

  // --------------------------------------------------------------
  // State, timers and outputs
  // --------------------------------------------------------------
  // Drive resets to zero, the locking level for the spring option;
  // without it the lock is applied one cycle after reset release.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q      <= S_INIT;
      magnet_drive <= 1'b0;
      safe_out     <= 1'b0;
      fault_q      <= 1'b0;
      fault_flag   <= 1'b0;
      dseen_q      <= 1'b0;
      dly_cnt_q    <= 15'd0;
      fb_cnt_q     <= 15'd0;
      fb_pend_q    <= 1'b1;
      warm_q       <= 2'h0;
    end else begin
      state_q      <= state_d;
      warm_q       <= {warm_q[0], 1'b1};
      magnet_drive <= drive_d;
      safe_out     <= safe_d & ~f_any & ~fault_q;
      dseen_q      <= dseen_d;
      if (f_any) begin
        fault_q <= 1'b1;
      end else if (fclr_wr) begin
        fault_q <= 1'b0;
      end
      fault_flag <= ctrl_q[`GLS_CTRL_FEN] & (fault_q | f_any);
      if (state_q != S_DELAY) begin
        dly_cnt_q <= 15'd0;
      end else if (tick && dly_cnt_q != 15'h7fff) begin
        dly_cnt_q <= dly_cnt_q + 15'd1;
      end
      // The synchronisers reset to zero, not to the pin level, so the
      // feedback check ignores them until two real samples are in.
      if (drive_d != magnet_drive) begin
        fb_pend_q <= 1'b1;
        fb_cnt_q  <= 15'd0;
      end else if (fb_pend_q && warm_q[1] && fbk == magnet_drive) begin
        fb_pend_q <= 1'b0;
      end else if (fb_pend_q && tick && fb_cnt_q != 15'h7fff) begin
        fb_cnt_q <= fb_cnt_q + 15'd1;
      end
    end
  end

  // --------------------------------------------------------------
  // Interrupt status
  // --------------------------------------------------------------
  wire       safe_nx = safe_d & ~f_any & ~fault_q;
  wire [3:0] ev;

  assign ev[`GLS_EV_FAULT]   = f_any & ~fault_q;
  assign ev[`GLS_EV_SAFE_UP] = ~safe_out & safe_nx;
  assign ev[`GLS_EV_SAFE_DN] = safe_out & ~safe_nx;
  assign ev[`GLS_EV_DRIVE]   = drive_d != magnet_drive;

  wire [3:0] iclr = (psel & penable & pready & pwrite &
                     (paddr == `GLS_ADDR_IRQ_CLR)) ? pwdata[3:0] : 4'h0;

  always @* begin
    ist_d = (ist_q & ~iclr) | ev; // Set wins over clear.
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_q <= 4'h0;
      irq   <= 1'b0;
    end else begin
      ist_q <= ist_d;
      irq   <= |(ist_d & ien_q);
    end
  end

  // --------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------
  // Zero wait: the answer is ready in the first access cycle, so
  // read data is prepared during the setup cycle.
  always @* begin
    rdata_d = 32'h0000_0000;
    rerr_d  = 1'b0;
    if (paddr == `GLS_ADDR_CTRL) begin
      rdata_d[3:0] = ctrl_q;
    end else if (paddr == `GLS_ADDR_RELDLY) begin
      rdata_d[4:0] = reldly_q;
    end else if (paddr == `GLS_ADDR_FBDLY) begin
      rdata_d[4:0] = fbdly_q;
    end else if (paddr == `GLS_ADDR_STATUS) begin
      rdata_d[9:0] = {req, door, fbk, dseen_q, fault_q, safe_out,
                      magnet_drive, state_q};
    end else if (paddr == `GLS_ADDR_IRQ_STAT) begin
      rdata_d[3:0] = ist_q;
    end else if (paddr == `GLS_ADDR_IRQ_EN) begin
      rdata_d[3:0] = ien_q;
    end else if (paddr == `GLS_ADDR_IRQ_CLR) begin
      rdata_d = 32'h0000_0000;
    end else begin
      rerr_d = 1'b1;
    end
  end

  wire wr = psel & penable & pready & pwrite & ~pslverr;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      prdata   <= 32'h0000_0000;
      ctrl_q   <= `GLS_CTRL_RST;
      reldly_q <= `GLS_RELDLY_RST;
      fbdly_q  <= `GLS_FBDLY_RST;
      ien_q    <= 4'h0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & rerr_d;
      if (psel && !penable && !pwrite) begin
        prdata <= rdata_d;
      end
      if (wr && paddr == `GLS_ADDR_CTRL) begin
        ctrl_q <= pwdata[3:0];
      end
      if (wr && paddr == `GLS_ADDR_RELDLY) begin
        reldly_q <= pwdata[4:0];
      end
      if (wr && paddr == `GLS_ADDR_FBDLY) begin
        fbdly_q <= pwdata[4:0];
      end
      if (wr && paddr == `GLS_ADDR_IRQ_EN) begin
        ien_q <= pwdata[3:0];
      end
    end
  end

endmodule // gls_guard_lock

`default_nettype wire

// *** gls_guard_lock_chk.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "gls_defines.vh"

module gls_chk #(
  parameter int TICK_CYCLES = 10
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        release_req,
  input wire logic        magnet_fbk,
  input wire logic        door_closed,
  input wire logic        magnet_drive,
  input wire logic        safe_out,
  input wire logic        fault_flag
);
  // --------
  // Mirror of the mode bits
  // --------
  // Modes are followed from completed bus writes, so the checker needs
  // no access to the register bodies.
  localparam int MIS_LIM = 13 * TICK_CYCLES;
  logic [3:0]  ctl_q;
  logic        rel_nz_q;
  logic        fb0_q;
  int unsigned mis_q;
  wire         wr_w = psel && penable && pready && pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_q    <= 4'h4;
      rel_nz_q <= 1'b1;
      fb0_q    <= 1'b0;
      mis_q    <= 0;
    end else begin
      if (wr_w && paddr == `GLS_ADDR_CTRL) ctl_q <= pwdata[3:0];
      if (wr_w && paddr == `GLS_ADDR_RELDLY) rel_nz_q <= |pwdata[4:0];
      if (wr_w && paddr == `GLS_ADDR_FBDLY) fb0_q <= ~|pwdata[4:0];
      if (fault_flag || magnet_fbk == magnet_drive) mis_q <= 0;
      else if (mis_q < MIS_LIM) mis_q <= mis_q + 1;
    end
  end

  // --------
  // Assertions
  // --------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_drop;
    ##[1:3] !safe_out;
  endsequence
  sequence s_hold;
    !magnet_drive [*8];
  endsequence

  chk_reset_quiet: assert property (
    !$past(presetn) |-> !safe_out && !fault_flag && !magnet_drive)
    else $error("outputs not quiet after reset");
  chk_req_drops_safe: assert property (
    $rose(release_req) |-> s_drop)
    else $error("safe output kept after request");
  chk_drive_after_safe: assert property (
    ctl_q[`GLS_CTRL_SPRING] && $rose(magnet_drive) |-> !$past(safe_out))
    else $error("drive released while safe");
  chk_release_wait: assert property (
    $fell(safe_out) && ctl_q[`GLS_CTRL_SPRING] && rel_nz_q |-> s_hold)
    else $error("drive released before delay");
  chk_fbk_timeout: assert property (
    ctl_q[`GLS_CTRL_FEN] && fb0_q && mis_q == MIS_LIM |-> fault_flag)
    else $error("feedback timeout not flagged");
  chk_flag_disabled: assert property (
    !ctl_q[`GLS_CTRL_FEN] && !$past(ctl_q[`GLS_CTRL_FEN]) |-> !fault_flag)
    else $error("fault flag while disabled");
  chk_door_open_fault: assert property (
    safe_out && !ctl_q[`GLS_CTRL_NDS] && !door_closed |-> ##[1:4] !safe_out)
    else $error("door open while locked kept safe");
  chk_nds_relock: assert property (
    ctl_q[`GLS_CTRL_NDS] && ctl_q[`GLS_CTRL_SPRING] && $fell(release_req)
      |-> ##[1:4] !magnet_drive)
    else $error("no relock after withdrawal");
endmodule // gls_chk
`default_nettype wire

// *** gls_magnet_model.sv ***
`timescale 1ns/100ps
`default_nettype none

module gls_magnet_model #(
  parameter int LAG = 30
) (
  input  wire logic pclk,
  input  wire logic magnet_drive,
  input  wire logic stuck,
  input  wire logic door_shut,
  output wire logic magnet_fbk,
  output wire logic door_closed
);
  // --------
  // Electromagnet and contacts
  // --------
  // The coil ignores the controller's reset, as a real one would.
  int   cnt_q = 0;
  logic fbk_q = 1'b0;

  assign magnet_fbk  = fbk_q;
  assign door_closed = door_shut;

  always_ff @(posedge pclk) begin
    if (stuck || fbk_q == magnet_drive) cnt_q <= 0;
    else if (cnt_q == LAG) fbk_q <= magnet_drive;
    else cnt_q <= cnt_q + 1;
  end
endmodule // gls_magnet_model
`default_nettype wire

// *** gls_guard_lock_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "gls_defines.vh"

module gls_guard_lock_tb_top;
  // --------
  // Bench state
  // --------
  localparam int TICK  = 10;
  localparam int LIMIT = 40000;
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] rst;
    logic [31:0] wd;
    logic [31:0] rb;
    logic        err;
  } gls_row_t;
  logic        pclk, presetn, psel, penable, pwrite;
  logic        release_req, door_shut, stuck;
  logic [7:0]  paddr;
  logic [31:0] pwdata, r;
  logic        e;
  wire  [31:0] prdata;
  wire         pready, pslverr, magnet_fbk, door_closed;
  wire         magnet_drive, safe_out, fault_flag, irq;
  int          n_fail, n_compared, cyc, i;
  gls_row_t    rows [5];

  gls_guard_lock #(.TICK_CYCLES(TICK)) gls_guard_lock_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .release_req(release_req),
    .magnet_fbk(magnet_fbk), .door_closed(door_closed),
    .magnet_drive(magnet_drive), .safe_out(safe_out),
    .fault_flag(fault_flag), .irq(irq));
  gls_magnet_model gls_magnet_model_inst (
    .pclk(pclk), .magnet_drive(magnet_drive), .stuck(stuck),
    .door_shut(door_shut), .magnet_fbk(magnet_fbk),
    .door_closed(door_closed));

  // --------
  // Tasks
  // --------
  task chk(input logic [31:0] seen, input logic [31:0] exp,
           input string what);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  function logic sel(input int k);
    return k == 0 ? safe_out : k == 1 ? magnet_drive : fault_flag;
  endfunction
  // A bounded wait, so a stuck output is reported, not hung on.
  task expect_in(input int k, input logic v, input int n, input string s);
    for (int j = 0; j < n && sel(k) !== v; j++) @(posedge pclk);
    chk(sel(k), v, s);
  endtask
  task results;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      n_fail++;
      results();
    end
  end

  // --------
  // Scenarios
  // --------
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {presetn, release_req, stuck, door_shut} = 4'b0001;
    rows = '{'{`GLS_ADDR_CTRL, 32'h4, 32'h1c, 32'hc, 1'b0},
             '{`GLS_ADDR_RELDLY, 32'h5, 32'h3f, 32'h1f, 1'b0},
             '{`GLS_ADDR_FBDLY, 32'h9, 32'hff, 32'h1f, 1'b0},
             '{`GLS_ADDR_IRQ_EN, 32'h0, 32'hff, 32'hf, 1'b0},
             '{8'h1c, 32'h0, 32'hff, 32'h0, 1'b1}};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 5; i++) begin
      apb(1'b0, rows[i].a, 32'h0);
      chk(r, rows[i].rst, "reset value");
      apb(1'b1, rows[i].a, rows[i].wd);
      apb(1'b0, rows[i].a, 32'h0);
      chk(r, rows[i].rb, "readback");
      chk(e, rows[i].err, "slverr");
    end
    apb(1'b1, `GLS_ADDR_RELDLY, 32'h1);
    apb(1'b1, `GLS_ADDR_FBDLY, 32'h0);
    expect_in(0, 1'b1, 2000, "safe at start");
    chk(magnet_drive, 1'b0, "drive locked");
    apb(1'b1, `GLS_ADDR_IRQ_CLR, 32'hf);
    release_req <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(safe_out, 1'b0, "safe on request");
    repeat (900) @(posedge pclk);
    chk(magnet_drive, 1'b0, "drive early");
    expect_in(1, 1'b1, 200, "drive released");
    repeat (60) @(posedge pclk);
    door_shut <= 1'b0;
    repeat (20) @(posedge pclk);
    release_req <= 1'b0;
    repeat (50) @(posedge pclk);
    chk(magnet_drive, 1'b1, "drive with door open");
    door_shut <= 1'b1;
    expect_in(1, 1'b0, 10, "relock");
    expect_in(0, 1'b1, 100, "safe after relock");
    chk(fault_flag, 1'b0, "no fault");
    chk(irq, 1'b1, "irq raised");
    apb(1'b0, `GLS_ADDR_IRQ_STAT, 32'h0);
    chk(r, 32'he, "event status");
    apb(1'b1, `GLS_ADDR_IRQ_EN, 32'h0);
    repeat (2) @(posedge pclk);
    chk(irq, 1'b0, "irq masked");
    apb(1'b1, `GLS_ADDR_IRQ_EN, 32'hf);
    apb(1'b1, `GLS_ADDR_IRQ_CLR, 32'hf);
    apb(1'b0, `GLS_ADDR_IRQ_STAT, 32'h0);
    chk({r[3:0], irq}, 5'h0, "status cleared");
    door_shut <= 1'b0;
    expect_in(2, 1'b1, 10, "door fault");
    chk(safe_out, 1'b0, "safe on door fault");
    apb(1'b0, `GLS_ADDR_IRQ_STAT, 32'h0);
    chk(r, 32'h5, "fault events");
    door_shut <= 1'b1;
    apb(1'b1, `GLS_ADDR_CTRL, 32'h1c);
    expect_in(0, 1'b1, 2000, "safe after clear");
    apb(1'b1, `GLS_ADDR_RELDLY, 32'h0);
    stuck <= 1'b1;
    release_req <= 1'b1;
    expect_in(2, 1'b1, 300, "feedback fault");
    chk(magnet_drive, 1'b0, "drive forced lock");
    {stuck, release_req} <= 2'b00;
    repeat (40) @(posedge pclk);
    apb(1'b1, `GLS_ADDR_CTRL, 32'h1c);
    expect_in(0, 1'b1, 2000, "safe after clear");
    apb(1'b1, `GLS_ADDR_CTRL, 32'he);
    release_req <= 1'b1;
    expect_in(1, 1'b1, 50, "mandatory release");
    repeat (60) @(posedge pclk);
    release_req <= 1'b0;
    expect_in(2, 1'b1, 300, "door never opened");
    apb(1'b1, `GLS_ADDR_CTRL, 32'h1d);
    door_shut <= 1'b0;
    expect_in(0, 1'b1, 2000, "safe without door");
    release_req <= 1'b1;
    expect_in(1, 1'b1, 50, "release without door");
    repeat (60) @(posedge pclk);
    release_req <= 1'b0;
    expect_in(1, 1'b0, 5, "relock on withdrawal");
    expect_in(0, 1'b1, 100, "safe again");
    door_shut <= 1'b1;
    apb(1'b1, `GLS_ADDR_CTRL, 32'h8);
    expect_in(1, 1'b1, 10, "energised lock");
    expect_in(0, 1'b1, 2000, "safe energised");
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk({magnet_drive, safe_out, fault_flag}, 3'h0, "in reset");
    presetn <= 1'b1;
    expect_in(0, 1'b1, 2000, "safe after reset");
    door_shut <= 1'b0;
    expect_in(0, 1'b0, 10, "safe on silent fault");
    repeat (4) @(posedge pclk);
    chk(fault_flag, 1'b0, "flag disabled");
    results();
  end
endmodule // gls_guard_lock_tb_top

bind gls_guard_lock gls_chk #(.TICK_CYCLES(TICK_CYCLES)) gls_chk_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .release_req(release_req), .magnet_fbk(magnet_fbk),
  .door_closed(door_closed), .magnet_drive(magnet_drive),
  .safe_out(safe_out), .fault_flag(fault_flag));
`default_nettype wire
